// ==== hdl/pd_power_indicator_mps.v ====
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "pd_power_indicator_consts.vh"

module pd_power_indicator_mps
#(
    parameter [`DLY_W-1:0] IND_DELAY_CYC = `IND_DELAY_CYC_DEF,
    parameter [`DLY_W-1:0] INRUSH_DELAY_CYC = `INRUSH_DELAY_CYC_DEF
)
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // analog monitor levels
    input wire uvlo_ok,
    input wire above_32v,
    input wire above_mark_reset,
    input wire thermal_shutdown,
    input wire inrush_current_done,
    input wire class_event,
    input wire pse_type34_detect,
    input wire load_current_high,
    // three-state duty select decoded to two levels
    input wire pulse_duty_select_short,
    input wire pulse_duty_select_open,
    // class resistor selects
    output reg early_class_resistor,
    output reg late_class_resistor,
    // open-drain power good
    output reg converter_go_output_o,
    output reg converter_go_output_oe,
    // indicators
    output reg power_tier_high_flag_o,
    output reg power_tier_high_flag_oe,
    output reg power_tier_low_flag_o,
    output reg power_tier_low_flag_oe,
    output reg pse_type_flag_o,
    output reg pse_type_flag_oe,
    // pulse drive and interrupt
    output wire mps_pulse_drive,
    output reg irq
);

localparam ST_OFF = 2'd0;
localparam ST_INRUSH = 2'd1;
localparam ST_POWER = 2'd2;
localparam ST_TSD = 2'd3;

wire [`NPIN-1:0] pin_raw;
reg [`NPIN-1:0] sync1_reg;
reg [`NPIN-1:0] sync2_reg;
reg class_d_reg;
reg [1:0] state_reg;
reg [1:0] state_next;
reg [`DLY_W-1:0] inr_cnt_reg;
reg [`DLY_W-1:0] ind_cnt_reg;
reg [2:0] cnt_reg;
reg type34_reg;
reg type_valid_reg;
reg ind_en_reg;
reg [1:0] ctrl_reg;
reg [`NIRQ-1:0] irq_status_reg;
reg [`NIRQ-1:0] irq_mask_reg;
reg [`NIRQ-1:0] irq_event;
reg [3:0] awaddr_reg;
reg [31:0] wdata_reg;
reg [3:0] wstrb_reg;
reg tier_hi;
reg tier_lo;
reg [9:0] on_ticks;
wire rd_clear;
wire uvlo_s;
wire above32_s;
wire mark_s;
wire tsd_s;
wire inr_done_s;
wire class_s;
wire class_rise;
wire inr_elapsed;
wire mps_en;
wire aw_have;
wire w_have;

assign pin_raw = {pulse_duty_select_open, pulse_duty_select_short,
                  load_current_high, pse_type34_detect, class_event,
                  inrush_current_done, thermal_shutdown, above_mark_reset,
                  above_32v, uvlo_ok};

// two-flop synchronisers for every pin
genvar gi;
generate
    for (gi = 0; gi < `NPIN; gi = gi + 1)
    begin : g_sync
        always @(posedge aclk)
        begin
            if (!aresetn)
            begin
                sync1_reg[gi] <= 1'b0;
                sync2_reg[gi] <= 1'b0;
            end
            else
            begin
                sync1_reg[gi] <= pin_raw[gi];
                sync2_reg[gi] <= sync1_reg[gi];
            end
        end
    end
endgenerate

assign uvlo_s = sync2_reg[`PIN_UVLO];
assign above32_s = sync2_reg[`PIN_ABOVE32];
assign mark_s = sync2_reg[`PIN_MARK];
assign tsd_s = sync2_reg[`PIN_TSD];
assign inr_done_s = sync2_reg[`PIN_INR_DONE];
assign class_s = sync2_reg[`PIN_CLASS];
assign class_rise = class_s && !class_d_reg;
assign inr_elapsed = !ctrl_reg[`CTRL_INR_DLY_EN] ||
                     (inr_cnt_reg >= INRUSH_DELAY_CYC);

// power state machine
always @*
begin
    state_next = state_reg;
    case (state_reg)
        ST_OFF:
            if (uvlo_s)
                state_next = ST_INRUSH;
        ST_INRUSH:
            if (!uvlo_s)
                state_next = ST_OFF;
            else if (tsd_s)
                state_next = ST_TSD;
            else if (inr_done_s && inr_elapsed)
                state_next = ST_POWER;
        ST_POWER:
            if (!uvlo_s)
                state_next = ST_OFF;
            else if (tsd_s)
                state_next = ST_TSD;
        ST_TSD:
            if (!uvlo_s)
                state_next = ST_OFF;
            else if (!tsd_s)
                state_next = ST_INRUSH;
        default:
            state_next = ST_OFF;
    endcase
end

// indicator encoding from event count and latched type
always @*
begin
    tier_hi = 1'b1;
    tier_lo = 1'b1;
    if (!type34_reg)
        tier_lo = (cnt_reg < `CNT_TWO);
    else if (cnt_reg >= `CNT_MAX)
    begin
        tier_hi = 1'b0;
        tier_lo = 1'b0;
    end
    else if (cnt_reg == `CNT_FOUR)
        tier_hi = 1'b0;
    else if (cnt_reg >= `CNT_TWO)
        tier_lo = 1'b0;
end

// duty select
always @*
begin
    if (!type34_reg)
        on_ticks = `DUTY_T12;
    else if (sync2_reg[`PIN_DUTY_SHORT])
        on_ticks = `DUTY_SHORT;
    else if (sync2_reg[`PIN_DUTY_OPEN])
        on_ticks = `DUTY_OPEN;
    else
        on_ticks = `DUTY_RES;
end

assign mps_en = (state_reg == ST_POWER) && ctrl_reg[`CTRL_MPS_EN] &&
                !sync2_reg[`PIN_LOAD_HI];

mps_pulse_gen u_mps
(
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(mps_en),
    .on_ticks(on_ticks),
    .pulse(mps_pulse_drive)
);

// core state, counters and outputs
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        class_d_reg <= 1'b0;
        state_reg <= ST_OFF;
        inr_cnt_reg <= {`DLY_W{1'b0}};
        ind_cnt_reg <= {`DLY_W{1'b0}};
        cnt_reg <= 3'd0;
        type34_reg <= 1'b0;
        type_valid_reg <= 1'b0;
        ind_en_reg <= 1'b0;
        early_class_resistor <= 1'b0;
        late_class_resistor <= 1'b0;
        converter_go_output_o <= 1'b0;
        converter_go_output_oe <= 1'b0;
        power_tier_high_flag_o <= 1'b0;
        power_tier_high_flag_oe <= 1'b0;
        power_tier_low_flag_o <= 1'b0;
        power_tier_low_flag_oe <= 1'b0;
        pse_type_flag_o <= 1'b0;
        pse_type_flag_oe <= 1'b0;
    end
    else
    begin
        class_d_reg <= class_s;
        state_reg <= state_next;
        if (state_reg != ST_INRUSH)
            inr_cnt_reg <= {`DLY_W{1'b0}};
        else if (inr_cnt_reg < INRUSH_DELAY_CYC)
            inr_cnt_reg <= inr_cnt_reg + 1'b1;
        if (state_reg != ST_POWER || !above32_s)
            ind_cnt_reg <= {`DLY_W{1'b0}};
        else if (ind_cnt_reg < IND_DELAY_CYC)
            ind_cnt_reg <= ind_cnt_reg + 1'b1;
        ind_en_reg <= (state_reg == ST_POWER) && above32_s && !tsd_s &&
                      (ind_cnt_reg >= IND_DELAY_CYC);
        if (!mark_s)
        begin
            cnt_reg <= 3'd0;
            type34_reg <= 1'b0;
            type_valid_reg <= 1'b0;
        end
        else
        begin
            if (class_rise && state_reg == ST_OFF && cnt_reg < `CNT_MAX)
                cnt_reg <= cnt_reg + 3'd1;
            if (state_reg == ST_OFF && state_next == ST_INRUSH &&
                !type_valid_reg)
            begin
                type34_reg <= sync2_reg[`PIN_TYPE34];
                type_valid_reg <= 1'b1;
            end
        end
        // the count steps one cycle after the rise, so the rise cycle
        // already belongs to the event that is starting
        early_class_resistor <= class_s && state_reg == ST_OFF &&
                                (cnt_reg < `CNT_TWO ||
                                 (cnt_reg == `CNT_TWO && !class_rise));
        late_class_resistor <= class_s && state_reg == ST_OFF &&
                               (cnt_reg > `CNT_TWO ||
                                (cnt_reg == `CNT_TWO && class_rise));
        converter_go_output_o <= 1'b0;
        converter_go_output_oe <= (state_next == ST_INRUSH);
        power_tier_high_flag_o <= tier_hi;
        power_tier_low_flag_o <= tier_lo;
        pse_type_flag_o <= !type34_reg;
        power_tier_high_flag_oe <= ind_en_reg;
        power_tier_low_flag_oe <= ind_en_reg;
        pse_type_flag_oe <= ind_en_reg;
    end
end

// interrupt events
always @*
begin
    irq_event = {`NIRQ{1'b0}};
    irq_event[`IRQ_CLASS] = class_rise && state_reg == ST_OFF;
    irq_event[`IRQ_IND_ON] = !ind_en_reg && (state_reg == ST_POWER) &&
                             above32_s && !tsd_s &&
                             (ind_cnt_reg >= IND_DELAY_CYC);
    irq_event[`IRQ_PG] = (state_reg == ST_INRUSH) && (state_next == ST_POWER);
    irq_event[`IRQ_TSD] = (state_reg != ST_TSD) && (state_next == ST_TSD);
    irq_event[`IRQ_MARK] = !mark_s && (type_valid_reg || cnt_reg != 3'd0);
end

assign aw_have = !s_axi_awready;
assign w_have = !s_axi_wready;
assign rd_clear = s_axi_arvalid && s_axi_arready &&
                  (s_axi_araddr == `ADDR_IRQ_STATUS);

// axi4-lite slave
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        awaddr_reg <= 4'h0;
        wdata_reg <= 32'h00000000;
        wstrb_reg <= 4'h0;
        ctrl_reg <= `CTRL_RESET;
        irq_mask_reg <= `IRQ_MASK_RESET;
        irq_status_reg <= {`NIRQ{1'b0}};
        irq <= 1'b0;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            awaddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        // both halves held: commit and answer
        if (aw_have && w_have && !s_axi_bvalid)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            case (awaddr_reg)
                `ADDR_CTRL:
                    if (wstrb_reg[0])
                        ctrl_reg <= wdata_reg[1:0];
                `ADDR_IRQ_MASK:
                    if (wstrb_reg[0])
                        irq_mask_reg <= wdata_reg[`NIRQ-1:0];
                `ADDR_STATUS, `ADDR_IRQ_STATUS:
                    s_axi_bresp <= `RESP_OKAY;
                default:
                    s_axi_bresp <= `RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            case (s_axi_araddr)
                `ADDR_CTRL:
                    s_axi_rdata[1:0] <= ctrl_reg;
                `ADDR_STATUS:
                    s_axi_rdata[11:0] <= {mps_pulse_drive, ind_en_reg,
                                          type_valid_reg, type34_reg,
                                          1'b0, cnt_reg, 2'b00, state_reg};
                `ADDR_IRQ_STATUS:
                    s_axi_rdata[`NIRQ-1:0] <= irq_status_reg;
                `ADDR_IRQ_MASK:
                    s_axi_rdata[`NIRQ-1:0] <= irq_mask_reg;
                default:
                    s_axi_rresp <= `RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        // new events win over the read clear
        if (rd_clear)
            irq_status_reg <= irq_event;
        else
            irq_status_reg <= irq_status_reg | irq_event;
        irq <= |(irq_status_reg & irq_mask_reg);
    end
end

endmodule

// ==== hdl/pd_power_indicator_consts.vh ====
`ifndef PD_POWER_INDICATOR_CONSTS_VH
`define PD_POWER_INDICATOR_CONSTS_VH

// timebase
`define CLK_MHZ 40
`define IND_DELAY_US 24000
`define INRUSH_DELAY_US 81500
`define DLY_W 22
// default delay counts in clock cycles at 40 MHz
`define IND_DELAY_CYC_DEF 22'd960000
`define INRUSH_DELAY_CYC_DEF 22'd3260000

// mps pulse timebase: one tick per microsecond, period in ticks
`define TICK_CYC 6'd40
`define TICK_LAST 6'd39
`define MPS_PERIOD_LAST 10'd999
`define DUTY_T12 10'd260
`define DUTY_SHORT 10'd125
`define DUTY_RES 10'd81
`define DUTY_OPEN 10'd54

// classification counter
`define CNT_MAX 3'd5
`define CNT_ONE 3'd1
`define CNT_TWO 3'd2
`define CNT_FOUR 3'd4

// pin input vector positions
`define NPIN 10
`define PIN_UVLO 0
`define PIN_ABOVE32 1
`define PIN_MARK 2
`define PIN_TSD 3
`define PIN_INR_DONE 4
`define PIN_CLASS 5
`define PIN_TYPE34 6
`define PIN_LOAD_HI 7
`define PIN_DUTY_SHORT 8
`define PIN_DUTY_OPEN 9

// register byte offsets
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_IRQ_STATUS 4'h8
`define ADDR_IRQ_MASK 4'hc

// control fields
`define CTRL_MPS_EN 0
`define CTRL_INR_DLY_EN 1
`define CTRL_RESET 2'h3

// interrupt fields
`define NIRQ 5
`define IRQ_CLASS 0
`define IRQ_IND_ON 1
`define IRQ_PG 2
`define IRQ_TSD 3
`define IRQ_MARK 4
`define IRQ_MASK_RESET 5'h00

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hdl/mps_pulse_gen.v ====
`timescale 1ns/100ps
`include "pd_power_indicator_consts.vh"

module mps_pulse_gen
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire enable,
    input wire [9:0] on_ticks,
    // pulse
    output reg pulse
);

reg [5:0] div_reg;
reg [9:0] phase_reg;
wire tick;

assign tick = (div_reg == `TICK_LAST);

// duty is on_ticks out of a fixed period of ticks
always @(posedge aclk)
begin
    if (!aresetn || !enable)
    begin
        div_reg <= 6'h00;
        phase_reg <= 10'h000;
        pulse <= 1'b0;
    end
    else
    begin
        div_reg <= tick ? 6'h00 : div_reg + 6'h01;
        if (tick)
        begin
            if (phase_reg == `MPS_PERIOD_LAST)
                phase_reg <= 10'h000;
            else
                phase_reg <= phase_reg + 10'h001;
        end
        pulse <= (phase_reg < on_ticks);
    end
end

endmodule

// ==== tb/pd_power_indicator_checker.sv ====
`timescale 1ns/100ps
`include "pd_power_indicator_consts.vh"
module pd_power_indicator_checker
#(
    parameter [`DLY_W-1:0] IND_DELAY_CYC = `IND_DELAY_CYC_DEF
)
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // monitor levels
    input wire above_32v,
    input wire thermal_shutdown,
    input wire load_current_high,
    // watched outputs
    input wire converter_go_output_o,
    input wire converter_go_output_oe,
    input wire power_tier_high_flag_o,
    input wire power_tier_high_flag_oe,
    input wire power_tier_low_flag_oe,
    input wire pse_type_flag_o,
    input wire pse_type_flag_oe,
    input wire mps_pulse_drive
);
reg [31:0] since_pg_reg;
reg [15:0] high_run_reg;
// cycles since power good was last pulled low
always @(posedge aclk)
begin
    if (!aresetn || converter_go_output_oe)
        since_pg_reg <= 32'h0;
    else if (since_pg_reg != 32'hffffffff)
        since_pg_reg <= since_pg_reg + 32'h1;
end
always @(posedge aclk)
begin
    if (!aresetn || !mps_pulse_drive)
        high_run_reg <= 16'h0;
    else
        high_run_reg <= high_run_reg + 16'h1;
end
default clocking cb @(posedge aclk);
endclocking
default disable iff (!aresetn);
sequence s_hot;
    thermal_shutdown [*7];
endsequence
sequence s_low_supply;
    !above_32v [*7];
endsequence
sequence s_load_high;
    load_current_high [*8];
endsequence
a_pg_pulls_low: assert property (converter_go_output_oe |-> !converter_go_output_o)
    else $error("power good driven high");
a_ind_enable_same: assert property (power_tier_high_flag_oe == pse_type_flag_oe && power_tier_low_flag_oe == pse_type_flag_oe)
    else $error("indicator enables differ");
a_ind_after_delay: assert property ($rose(pse_type_flag_oe) |-> since_pg_reg >= IND_DELAY_CYC - 1)
    else $error("indicators enabled too early");
a_ind_off_inrush: assert property (converter_go_output_oe |-> !power_tier_high_flag_oe)
    else $error("indicators driven in inrush");
a_ind_off_hot: assert property (s_hot |-> !power_tier_high_flag_oe)
    else $error("indicators driven in thermal shutdown");
a_ind_off_low: assert property (s_low_supply |-> !pse_type_flag_oe)
    else $error("indicators driven below 32 V");
a_pulse_off_load: assert property (s_load_high |-> !mps_pulse_drive)
    else $error("pulse while load current high");
a_type12_tier: assert property (pse_type_flag_oe && pse_type_flag_o |-> power_tier_high_flag_o)
    else $error("type 1-2 with tier high low");
a_pulse_width: assert property (mps_pulse_drive |-> high_run_reg <= 16'd10401)
    else $error("pulse longer than widest duty");
endmodule
bind pd_power_indicator_mps pd_power_indicator_checker #(.IND_DELAY_CYC(IND_DELAY_CYC)) pd_power_indicator_checker_inst (.aclk, .aresetn, .above_32v, .thermal_shutdown, .load_current_high, .converter_go_output_o, .converter_go_output_oe, .power_tier_high_flag_o, .power_tier_high_flag_oe, .power_tier_low_flag_oe, .pse_type_flag_o, .pse_type_flag_oe, .mps_pulse_drive);

// ==== tb/pse_load_model.sv ====
`timescale 1ns/100ps
module pse_load_model
(
    // clock
    input wire aclk,
    // command from the bench
    input wire start,
    input wire [2:0] n_ev,
    input wire t34,
    // levels seen by the device
    output reg class_event,
    output reg uvlo_ok,
    output reg above_mark_reset,
    output reg pse_type34_detect,
    output reg inrush_current_done
);
integer i;
initial
begin
    class_event = 1'h0;
    uvlo_ok = 1'h0;
    above_mark_reset = 1'h1;
    pse_type34_detect = 1'h0;
    inrush_current_done = 1'h0;
end
// power off, mark reset, classify, then power up
always
begin
    @(posedge aclk);
    if (start)
    begin
        uvlo_ok <= 1'h0;
        inrush_current_done <= 1'h0;
        above_mark_reset <= 1'h0;
        repeat (6) @(posedge aclk);
        above_mark_reset <= 1'h1;
        pse_type34_detect <= t34;
        repeat (4) @(posedge aclk);
        for (i = 0; i < n_ev; i = i + 1)
        begin
            class_event <= 1'h1;
            repeat (8) @(posedge aclk);
            class_event <= 1'h0;
            repeat (8) @(posedge aclk);
        end
        uvlo_ok <= 1'h1;
        repeat (10) @(posedge aclk);
        inrush_current_done <= 1'h1;
    end
end
endmodule

// ==== tb/pd_power_indicator_mps_tb_top.sv ====
`timescale 1ns/100ps
`include "pd_power_indicator_consts.vh"
module pd_power_indicator_mps_tb_top;
reg aclk = 1'h0;
reg aresetn = 1'h0;
reg [3:0] s_axi_awaddr = 4'h0;
reg [3:0] s_axi_araddr = 4'h0;
reg [3:0] s_axi_wstrb = 4'h0;
reg [31:0] s_axi_wdata = 32'h0;
reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
reg above_32v = 1'h1, thermal_shutdown = 1'h0, load_current_high = 1'h0;
reg pulse_duty_select_short = 1'h0, pulse_duty_select_open = 1'h0;
reg start = 1'h0, t34 = 1'h0;
reg [2:0] n_ev = 3'h1;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
wire s_axi_rvalid, uvlo_ok, above_mark_reset, inrush_current_done;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire class_event, pse_type34_detect, converter_go_output_o;
wire converter_go_output_oe, power_tier_high_flag_o;
wire power_tier_high_flag_oe, power_tier_low_flag_o;
wire power_tier_low_flag_oe, pse_type_flag_o, pse_type_flag_oe;
wire mps_pulse_drive, irq;
wire early_class_resistor, late_class_resistor;
integer failures = 0, cmp_count = 0, seed = 98, i, k;
integer ne = 0, nl = 0;
reg pe = 1'h0, pl = 1'h0;
reg [31:0] rd;
reg [1:0] rsp;
always #12.5 aclk = ~aclk;
pd_power_indicator_mps #(.IND_DELAY_CYC(22'h14), .INRUSH_DELAY_CYC(22'h28))
    pd_power_indicator_mps_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uvlo_ok,
    .above_32v, .above_mark_reset, .thermal_shutdown,
    .inrush_current_done, .class_event, .pse_type34_detect,
    .load_current_high, .pulse_duty_select_short, .pulse_duty_select_open,
    .early_class_resistor, .late_class_resistor, .converter_go_output_o,
    .converter_go_output_oe, .power_tier_high_flag_o,
    .power_tier_high_flag_oe, .power_tier_low_flag_o,
    .power_tier_low_flag_oe, .pse_type_flag_o, .pse_type_flag_oe,
    .mps_pulse_drive, .irq);
pse_load_model pse_load_model_inst (.aclk, .start, .n_ev, .t34,
    .class_event, .uvlo_ok, .above_mark_reset, .pse_type34_detect,
    .inrush_current_done);
// rising edges of the class resistor selects
always @(posedge aclk)
begin
    pe <= early_class_resistor;
    pl <= late_class_resistor;
    if (early_class_resistor && !pe)
        ne <= ne + 1;
    if (late_class_resistor && !pl)
        nl <= nl + 1;
end
task print_verdict;
begin
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
end
endtask
task hang;
begin
    failures = failures + 1;
    $display("ERROR wait expected done seen timeout");
    print_verdict;
end
endtask
task cmp(input string nm, input [31:0] e, input [31:0] g);
begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
        failures = failures + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
    end
end
endtask
// {tier high, tier low, type flag} from group and event count
function [2:0] enc(input x, input [2:0] n);
begin
    if (!x)
        enc = (n >= 3'h2) ? 3'h5 : 3'h7;
    else if (n <= 3'h1)
        enc = 3'h6;
    else if (n <= 3'h3)
        enc = 3'h4;
    else
        enc = (n == 3'h4) ? 3'h2 : 3'h0;
end
endfunction
function sig(input [1:0] w);
begin
    case (w)
        2'h0: sig = pse_type_flag_oe;
        2'h1: sig = converter_go_output_oe;
        default: sig = mps_pulse_drive;
    endcase
end
endfunction
task wait_for(input [1:0] w, input v, input integer lim);
    integer n;
begin
    n = 0;
    while (sig(w) !== v && n < lim)
    begin
        @(posedge aclk);
        n = n + 1;
    end
    if (n == lim)
        hang;
end
endtask
task axw(input [3:0] a, input [31:0] d);
    reg aw, w, b;
    integer n;
begin
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h1;
    n = 0;
    while ((aw || w || b) && n < 100)
    begin
        @(posedge aclk);
        n = n + 1;
        if (aw && s_axi_awready === 1'h1)
        begin
            aw = 1'h0;
            s_axi_awvalid <= 1'h0;
        end
        if (w && s_axi_wready === 1'h1)
        begin
            w = 1'h0;
            s_axi_wvalid <= 1'h0;
        end
        if (b && s_axi_bvalid === 1'h1)
        begin
            b = 1'h0;
            s_axi_bready <= 1'h0;
            rsp = s_axi_bresp;
        end
    end
    @(posedge aclk);
    if (n == 100)
        hang;
end
endtask
task axr(input [3:0] a);
    reg ar, r;
    integer n;
begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    ar = 1'h1;
    r = 1'h1;
    n = 0;
    while ((ar || r) && n < 100)
    begin
        @(posedge aclk);
        n = n + 1;
        if (ar && s_axi_arready === 1'h1)
        begin
            ar = 1'h0;
            s_axi_arvalid <= 1'h0;
        end
        if (r && s_axi_rvalid === 1'h1)
        begin
            r = 1'h0;
            s_axi_rready <= 1'h0;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
        end
    end
    @(posedge aclk);
    if (n == 100)
        hang;
end
endtask
task ind_check(input [2:0] e);
begin
    wait_for(2'h1, 1'h0, 2000);
    wait_for(2'h0, 1'h1, 2000);
    cmp("indicators", e, {power_tier_high_flag_o, power_tier_low_flag_o, pse_type_flag_o});
end
endtask
task run_case(input x, input [2:0] n);
    integer e0, l0;
begin
    e0 = ne;
    l0 = nl;
    t34 <= x;
    n_ev <= n;
    start <= 1'h1;
    @(posedge aclk);
    start <= 1'h0;
    wait_for(2'h1, 1'h1, 2000);
    cmp("early resistor", (n > 3'h2) ? 3'h2 : n, ne - e0);
    cmp("late resistor", (n > 3'h2) ? n - 3'h2 : 3'h0, nl - l0);
    ind_check(enc(x, n));
end
endtask
// pulse stops under load, then one on-time is measured in ticks
task meas(input [9:0] t);
    integer c;
begin
    load_current_high <= 1'h1;
    repeat (10) @(posedge aclk);
    cmp("pulse under load", 32'h0, mps_pulse_drive);
    load_current_high <= 1'h0;
    wait_for(2'h2, 1'h1, 41000);
    c = 0;
    while (mps_pulse_drive === 1'h1 && c < 11000)
    begin
        @(posedge aclk);
        c = c + 1;
    end
    cmp("on ticks", t, (c + 20) / `TICK_CYC);
end
endtask
initial
begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axr(`ADDR_CTRL);
    cmp("ctrl reset", 32'h3, rd);
    axw(`ADDR_IRQ_MASK, 32'h1f);
    run_case(1'h0, 3'h1);
    repeat (3) @(posedge aclk);
    cmp("irq raised", 32'h1, irq);
    axr(`ADDR_IRQ_STATUS);
    cmp("irq bits", 32'h7, rd[2:0]);
    repeat (3) @(posedge aclk);
    cmp("irq cleared", 32'h0, irq);
    axw(`ADDR_STATUS, 32'h0);
    cmp("read only resp", `RESP_OKAY, rsp);
    axw(`ADDR_IRQ_MASK, 32'h0);
    k = $random(seed);
    pulse_duty_select_short <= k[0];
    meas(`DUTY_T12);
    run_case(1'h0, 3'h2);
    for (i = 1; i < 6; i = i + 1)
        run_case(1'h1, i[2:0]);
    for (i = 0; i < 4; i = i + 1)
    begin
        k = $random(seed);
        run_case(k[3], k[3] ? 3'(k[2:0] % 5 + 1) : 3'(k[0] + 1));
    end
    cmp("irq masked", 32'h0, irq);
    run_case(1'h1, 3'h4);
    above_32v <= 1'h0;
    repeat (10) @(posedge aclk);
    cmp("release low supply", 32'h0, pse_type_flag_oe);
    above_32v <= 1'h1;
    ind_check(3'h2);
    thermal_shutdown <= 1'h1;
    repeat (10) @(posedge aclk);
    cmp("release hot", 32'h0, pse_type_flag_oe);
    thermal_shutdown <= 1'h0;
    wait_for(2'h1, 1'h1, 2000);
    ind_check(3'h2);
    for (i = 0; i < 3; i = i + 1)
    begin
        pulse_duty_select_short <= (i == 0);
        pulse_duty_select_open <= (i == 2);
        meas(i == 0 ? `DUTY_SHORT : i == 1 ? `DUTY_RES : `DUTY_OPEN);
    end
    print_verdict;
end
endmodule
